// ==== lpds_pkg.sv ====
`default_nettype none
package lpds_pkg;
	localparam logic [31:0] REF_CTRL_OFS  = 32'h0000_2050;
	localparam logic [31:0] DATA_OFS      = 32'h0000_2120;
	localparam logic [31:0] SWITCH_OFS    = 32'h0000_2124;
	localparam logic [31:0] CONFIG_OFS    = 32'h0000_2128;
	localparam logic [31:0] CM_SEL_OFS    = 32'h0000_235c;

	localparam int OVERRIDE_BIT  = 5;
	localparam int SW_MSB        = 4;
	localparam int SW_BIAS_POT_BIT   = 4;
	localparam int SW_BIAS_FILT_BIT  = 3;
	localparam int SW_ZERO_LPTIA_BIT = 2;
	localparam int SW_ZERO_FILT_BIT  = 1;
	localparam int SW_ZERO_HSTIA_BIT = 0;
	localparam int SIX_MSB       = 17;
	localparam int SIX_LSB       = 12;
	localparam int TWELVE_MSB    = 11;
	localparam int BUF_PD_BIT    = 1;
	localparam int BG_PD_BIT     = 0;
	localparam int CM_EN_BIT     = 3;
	localparam int CM_RSV_MSB    = 2;
	localparam int DIAG_BIT      = 5;
	localparam int WREN_BIT      = 0;
	localparam int CFG_MSB       = 6;

	localparam logic [5:0]  SWITCH_RST    = 6'h0c;
	localparam logic [6:0]  CONFIG_RST    = 7'h02;
	localparam logic [4:0]  SW_NORMAL     = 5'h0c;
	localparam logic [4:0]  SW_DIAG       = 5'h09;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'h0;
	localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
endpackage : lpds_pkg
`default_nettype wire

// ==== lpds_regs.sv ====
// Function
// - With the override clear, the output switches follow the diagnostic-mode bit of the config register.
// - With the override set, the five switches follow switch-register bits 4 to 0 and the mode bit is ignored.
// - Switch bit 4 closes the bias-to-potentiostat switch when 1, resets to 0.
// - Switch bit 3 closes the bias-to-filter-pin switch when 1, resets to 1.
// - Switch bit 2 closes the zero-to-low-power-TIA switch when 1, resets to 1.
// - Switch bit 1 closes the zero-to-filter-pin switch when 1.
// - Switch bit 0 closes the zero-to-high-speed-TIA switch when 1, resets to 0.
// - Data bits 17 to 12 hold the read/write six-bit DAC code.
// - Data bits 11 to 0 hold the read/write twelve-bit DAC code.
// - Reference bit 1 set powers down the 2.5 V buffer, clear enables it, reset 0.
// - Reference bit 0 set powers down the bandgap, clear enables it, reset 0.
// - Common-mode bit 3 enables the common-mode switches, reset 0.
// - Common-mode bits 31 to 4 read zero, bits 2 to 0 are plain read/write storage resetting to 0.
// - With the data write-enable bit clear, data writes are blocked and the data register reads zero.
// - Config bit 5 selects normal switching when 0 and diagnostic when 1, only while override is clear.
//
// Chosen here: register access over AHB-Lite.
`default_nettype none
module lpds_regs
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             biasToPotentiostatSwitch,
	output logic             biasToFilterPinSwitch,
	output logic             zeroToLowpowerTiaSwitch,
	output logic             zeroToFilterPinSwitch,
	output logic             zeroToHighspeedTiaSwitch,
	output logic      [5:0]  sixBitCode,
	output logic      [11:0] twelveBitCode,
	output logic             refBufferPowerdown,
	output logic             bandgapPowerdown,
	output logic             commonModeEnable
);
	logic        rstMeta_r;
	logic        rstN;
	logic        dphValid_r;
	logic        dphWrite_r;
	logic [31:0] dphAddr_r;
	logic        wrStrobe;
	logic [5:0]  switch_r;
	logic [6:0]  config_r;
	logic [17:0] data_r;
	logic [1:0]  refCtrl_r;
	logic [3:0]  cmSel_r;
	logic [31:0] rdMux;
	logic [4:0]  switchSel;

	// Reset release through two flops
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rstMeta_r <= 1'b0;
			rstN      <= 1'b0;
		end
		else
		begin
			rstMeta_r <= 1'b1;
			rstN      <= rstMeta_r;
		end
	end

	// Address phase capture
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			dphValid_r <= 1'b0;
			dphWrite_r <= 1'b0;
			dphAddr_r  <= lpds_pkg::ZERO_WORD;
		end
		else if (hready)
		begin
			dphValid_r <= hsel && (htrans == lpds_pkg::HTRANS_NONSEQ || htrans[1]);
			dphWrite_r <= hwrite;
			dphAddr_r  <= haddr;
		end
	end

	// One wait state on reads so data reflects a just-finished write
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			hreadyout <= 1'b1;
		else if (hready && hsel && htrans[1] && !hwrite)
			hreadyout <= 1'b0;
		else
			hreadyout <= 1'b1;
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			hresp <= lpds_pkg::HRESP_OKAY;
		else
			hresp <= lpds_pkg::HRESP_OKAY;
	end

	assign wrStrobe = dphValid_r && dphWrite_r && hready;

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			switch_r <= lpds_pkg::SWITCH_RST;
		else if (wrStrobe && dphAddr_r == lpds_pkg::SWITCH_OFS)
			switch_r <= hwdata[lpds_pkg::OVERRIDE_BIT:0];
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			config_r <= lpds_pkg::CONFIG_RST;
		else if (wrStrobe && dphAddr_r == lpds_pkg::CONFIG_OFS)
			config_r <= hwdata[lpds_pkg::CFG_MSB:0];
	end

	// Data register held at zero while writes are disabled
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			data_r <= '0;
		else if (!config_r[lpds_pkg::WREN_BIT])
			data_r <= '0;
		else if (wrStrobe && dphAddr_r == lpds_pkg::DATA_OFS)
			data_r <= hwdata[lpds_pkg::SIX_MSB:0];
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			refCtrl_r <= '0;
		else if (wrStrobe && dphAddr_r == lpds_pkg::REF_CTRL_OFS)
			refCtrl_r <= hwdata[lpds_pkg::BUF_PD_BIT:0];
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			cmSel_r <= '0;
		else if (wrStrobe && dphAddr_r == lpds_pkg::CM_SEL_OFS)
			cmSel_r <= hwdata[lpds_pkg::CM_EN_BIT:0];
	end

	// Read mux; reserved bits and unmapped space read zero
	always_comb
	begin
		rdMux = lpds_pkg::ZERO_WORD;
		if (dphAddr_r == lpds_pkg::SWITCH_OFS)
			rdMux[lpds_pkg::OVERRIDE_BIT:0] = switch_r;
		else if (dphAddr_r == lpds_pkg::CONFIG_OFS)
			rdMux[lpds_pkg::CFG_MSB:0] = config_r;
		else if (dphAddr_r == lpds_pkg::DATA_OFS && config_r[lpds_pkg::WREN_BIT])
			rdMux[lpds_pkg::SIX_MSB:0] = data_r;
		else if (dphAddr_r == lpds_pkg::REF_CTRL_OFS)
			rdMux[lpds_pkg::BUF_PD_BIT:0] = refCtrl_r;
		else if (dphAddr_r == lpds_pkg::CM_SEL_OFS)
			rdMux[lpds_pkg::CM_EN_BIT:0] = cmSel_r;
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			hrdata <= lpds_pkg::ZERO_WORD;
		else if (dphValid_r && !dphWrite_r && !hreadyout)
			hrdata <= rdMux;
	end

	// Switch source: override bits or mode pattern
	always_comb
	begin
		if (switch_r[lpds_pkg::OVERRIDE_BIT])
			switchSel = switch_r[lpds_pkg::SW_MSB:0];
		else if (config_r[lpds_pkg::DIAG_BIT])
			switchSel = lpds_pkg::SW_DIAG;
		else
			switchSel = lpds_pkg::SW_NORMAL;
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			biasToPotentiostatSwitch <= 1'b0;
			biasToFilterPinSwitch    <= 1'b0;
			zeroToLowpowerTiaSwitch  <= 1'b0;
			zeroToFilterPinSwitch    <= 1'b0;
			zeroToHighspeedTiaSwitch <= 1'b0;
		end
		else
		begin
			biasToPotentiostatSwitch <= switchSel[lpds_pkg::SW_BIAS_POT_BIT];
			biasToFilterPinSwitch    <= switchSel[lpds_pkg::SW_BIAS_FILT_BIT];
			zeroToLowpowerTiaSwitch  <= switchSel[lpds_pkg::SW_ZERO_LPTIA_BIT];
			zeroToFilterPinSwitch    <= switchSel[lpds_pkg::SW_ZERO_FILT_BIT];
			zeroToHighspeedTiaSwitch <= switchSel[lpds_pkg::SW_ZERO_HSTIA_BIT];
		end
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			sixBitCode         <= '0;
			twelveBitCode      <= '0;
			refBufferPowerdown <= 1'b0;
			bandgapPowerdown   <= 1'b0;
			commonModeEnable   <= 1'b0;
		end
		else
		begin
			sixBitCode         <= data_r[lpds_pkg::SIX_MSB:lpds_pkg::SIX_LSB];
			twelveBitCode      <= data_r[lpds_pkg::TWELVE_MSB:0];
			refBufferPowerdown <= refCtrl_r[lpds_pkg::BUF_PD_BIT];
			bandgapPowerdown   <= refCtrl_r[lpds_pkg::BG_PD_BIT];
			commonModeEnable   <= cmSel_r[lpds_pkg::CM_EN_BIT];
		end
	end

	// Checks
	override_follow_a : assert property (@(posedge clk) disable iff (!rstN)
		switch_r[lpds_pkg::OVERRIDE_BIT] |=> biasToPotentiostatSwitch == $past(switch_r[lpds_pkg::SW_MSB])
			&& zeroToHighspeedTiaSwitch == $past(switch_r[lpds_pkg::SW_ZERO_HSTIA_BIT]))
		else $error("override switches wrong");
	diag_mode_a : assert property (@(posedge clk) disable iff (!rstN)
		!switch_r[lpds_pkg::OVERRIDE_BIT] && config_r[lpds_pkg::DIAG_BIT] |=> zeroToHighspeedTiaSwitch)
		else $error("diagnostic pattern wrong");
	normal_mode_a : assert property (@(posedge clk) disable iff (!rstN)
		!switch_r[lpds_pkg::OVERRIDE_BIT] && !config_r[lpds_pkg::DIAG_BIT]
			|=> zeroToLowpowerTiaSwitch && !zeroToHighspeedTiaSwitch)
		else $error("normal pattern wrong");
	data_block_a : assert property (@(posedge clk) disable iff (!rstN)
		!config_r[lpds_pkg::WREN_BIT] |=> data_r == '0)
		else $error("data not held at zero");
	data_write_a : assert property (@(posedge clk) disable iff (!rstN)
		wrStrobe && dphAddr_r == lpds_pkg::DATA_OFS && config_r[lpds_pkg::WREN_BIT]
			|=> ##1 sixBitCode == $past(hwdata[lpds_pkg::SIX_MSB:lpds_pkg::SIX_LSB], 2))
		else $error("six-bit code not written");
	twelve_write_a : assert property (@(posedge clk) disable iff (!rstN)
		wrStrobe && dphAddr_r == lpds_pkg::DATA_OFS && config_r[lpds_pkg::WREN_BIT]
			|=> ##1 twelveBitCode == $past(hwdata[lpds_pkg::TWELVE_MSB:0], 2))
		else $error("twelve-bit code not written");
	data_rsv_a : assert property (@(posedge clk) disable iff (!rstN)
		!hreadyout && dphAddr_r == lpds_pkg::DATA_OFS |=> hrdata[31:18] == '0)
		else $error("data reserved bits set");
	cm_rsv_a : assert property (@(posedge clk) disable iff (!rstN)
		!hreadyout && dphAddr_r == lpds_pkg::CM_SEL_OFS |=> hrdata[31:4] == '0)
		else $error("common-mode reserved bits set");
	ref_pd_a : assert property (@(posedge clk) disable iff (!rstN)
		wrStrobe && dphAddr_r == lpds_pkg::REF_CTRL_OFS
			|=> ##1 refBufferPowerdown == $past(hwdata[lpds_pkg::BUF_PD_BIT], 2)
			&& bandgapPowerdown == $past(hwdata[lpds_pkg::BG_PD_BIT], 2))
		else $error("reference power-down wrong");
	cm_en_a : assert property (@(posedge clk) disable iff (!rstN)
		wrStrobe && dphAddr_r == lpds_pkg::CM_SEL_OFS
			|=> ##1 commonModeEnable == $past(hwdata[lpds_pkg::CM_EN_BIT], 2))
		else $error("common-mode enable wrong");
	read_wait_a : assert property (@(posedge clk) disable iff (!rstN)
		!hreadyout |=> hreadyout)
		else $error("read wait too long");

	// Per-switch override routing
	bias_pot_a : assert property (@(posedge clk) disable iff (!rstN)
		switch_r[lpds_pkg::OVERRIDE_BIT]
			|=> biasToPotentiostatSwitch == $past(switch_r[lpds_pkg::SW_BIAS_POT_BIT]))
		else $error("potentiostat switch wrong");
	bias_filter_a : assert property (@(posedge clk) disable iff (!rstN)
		switch_r[lpds_pkg::OVERRIDE_BIT]
			|=> biasToFilterPinSwitch == $past(switch_r[lpds_pkg::SW_BIAS_FILT_BIT]))
		else $error("bias filter switch wrong");
	lowpower_tia_a : assert property (@(posedge clk) disable iff (!rstN)
		switch_r[lpds_pkg::OVERRIDE_BIT]
			|=> zeroToLowpowerTiaSwitch == $past(switch_r[lpds_pkg::SW_ZERO_LPTIA_BIT]))
		else $error("low-power TIA switch wrong");
	zero_filter_a : assert property (@(posedge clk) disable iff (!rstN)
		switch_r[lpds_pkg::OVERRIDE_BIT]
			|=> zeroToFilterPinSwitch == $past(switch_r[lpds_pkg::SW_ZERO_FILT_BIT]))
		else $error("zero filter switch wrong");
	highspeed_tia_a : assert property (@(posedge clk) disable iff (!rstN)
		switch_r[lpds_pkg::OVERRIDE_BIT]
			|=> zeroToHighspeedTiaSwitch == $past(switch_r[lpds_pkg::SW_ZERO_HSTIA_BIT]))
		else $error("high-speed TIA switch wrong");

	// Whole mode patterns, switch reset value and reset release
	diag_pattern_a : assert property (@(posedge clk) disable iff (!rstN)
		!switch_r[lpds_pkg::OVERRIDE_BIT] && config_r[lpds_pkg::DIAG_BIT]
			|=> {biasToPotentiostatSwitch, biasToFilterPinSwitch, zeroToLowpowerTiaSwitch, zeroToFilterPinSwitch,
			zeroToHighspeedTiaSwitch} == lpds_pkg::SW_DIAG)
		else $error("diagnostic switch set wrong");
	normal_pattern_a : assert property (@(posedge clk) disable iff (!rstN)
		!switch_r[lpds_pkg::OVERRIDE_BIT] && !config_r[lpds_pkg::DIAG_BIT]
			|=> {biasToPotentiostatSwitch, biasToFilterPinSwitch, zeroToLowpowerTiaSwitch, zeroToFilterPinSwitch,
			zeroToHighspeedTiaSwitch} == lpds_pkg::SW_NORMAL)
		else $error("normal switch set wrong");
	switch_reset_a : assert property (@(posedge clk) disable iff (!rstN)
		$rose(rstN) |-> switch_r == lpds_pkg::SWITCH_RST)
		else $error("switch reset value wrong");
	rst_release_a : assert property (@(posedge clk)
		$rose(rstN) |-> $past(rstMeta_r))
		else $error("reset released without sync stage");

	// Register storage, read data and no wait state on writes
	switch_write_a : assert property (@(posedge clk) disable iff (!rstN)
		wrStrobe && dphAddr_r == lpds_pkg::SWITCH_OFS |=> switch_r == $past(hwdata[lpds_pkg::OVERRIDE_BIT:0]))
		else $error("switch register not written");
	config_write_a : assert property (@(posedge clk) disable iff (!rstN)
		wrStrobe && dphAddr_r == lpds_pkg::CONFIG_OFS |=> config_r == $past(hwdata[lpds_pkg::CFG_MSB:0]))
		else $error("config register not written");
	cm_low_rw_a : assert property (@(posedge clk) disable iff (!rstN)
		wrStrobe && dphAddr_r == lpds_pkg::CM_SEL_OFS
			|=> cmSel_r[lpds_pkg::CM_RSV_MSB:0] == $past(hwdata[lpds_pkg::CM_RSV_MSB:0]))
		else $error("common-mode low bits not stored");
	ref_hold_a : assert property (@(posedge clk) disable iff (!rstN)
		!(wrStrobe && dphAddr_r == lpds_pkg::REF_CTRL_OFS) |=> $stable(refCtrl_r))
		else $error("reference control changed unasked");
	cm_hold_a : assert property (@(posedge clk) disable iff (!rstN)
		!(wrStrobe && dphAddr_r == lpds_pkg::CM_SEL_OFS) |=> $stable(cmSel_r))
		else $error("common-mode select changed unasked");
	switch_hold_a : assert property (@(posedge clk) disable iff (!rstN)
		!(wrStrobe && dphAddr_r == lpds_pkg::SWITCH_OFS) |=> $stable(switch_r))
		else $error("switch register changed unasked");
	data_read_zero_a : assert property (@(posedge clk) disable iff (!rstN)
		dphValid_r && !dphWrite_r && !hreadyout && dphAddr_r == lpds_pkg::DATA_OFS && !config_r[lpds_pkg::WREN_BIT]
			|=> hrdata == lpds_pkg::ZERO_WORD)
		else $error("blocked data register not read as zero");
	code_clear_a : assert property (@(posedge clk) disable iff (!rstN)
		!config_r[lpds_pkg::WREN_BIT] ##1 !config_r[lpds_pkg::WREN_BIT]
			|=> sixBitCode == '0 && twelveBitCode == '0)
		else $error("codes not cleared while blocked");
	write_nowait_a : assert property (@(posedge clk) disable iff (!rstN)
		hready && hsel && htrans[1] && hwrite |=> hreadyout)
		else $error("write stalled");
	read_capture_a : assert property (@(posedge clk) disable iff (!rstN)
		dphValid_r && !dphWrite_r && !hreadyout |=> hrdata == $past(rdMux))
		else $error("read data not captured");

	override_use_c : cover property (@(posedge clk) disable iff (!rstN)
		wrStrobe && dphAddr_r == lpds_pkg::SWITCH_OFS && hwdata[lpds_pkg::OVERRIDE_BIT]);
	diag_use_c : cover property (@(posedge clk) disable iff (!rstN)
		!switch_r[lpds_pkg::OVERRIDE_BIT] && config_r[lpds_pkg::DIAG_BIT]);
	blocked_write_c : cover property (@(posedge clk) disable iff (!rstN)
		wrStrobe && dphAddr_r == lpds_pkg::DATA_OFS && !config_r[lpds_pkg::WREN_BIT]);
	read_data_c : cover property (@(posedge clk) disable iff (!rstN)
		!hreadyout && dphAddr_r == lpds_pkg::DATA_OFS);
	data_write_c : cover property (@(posedge clk) disable iff (!rstN)
		wrStrobe && dphAddr_r == lpds_pkg::DATA_OFS && config_r[lpds_pkg::WREN_BIT]);
endmodule : lpds_regs
`default_nettype wire

// ==== lpds_analog_model.sv ====
`default_nettype none
module lpds_analog_model
(
	input wire logic [5:0]  sixBitCode,
	input wire logic [11:0] twelveBitCode
);
	timeunit 1ns;
	timeprecision 1ps;
	int zeroLevelUv;
	int biasLevelUv;
	// Ideal DAC levels in microvolts
	always_comb
	begin
		zeroLevelUv = 200000 + 34375 * int'(sixBitCode);
		biasLevelUv = 200000 + 537 * int'(twelveBitCode);
	end
endmodule : lpds_analog_model
`default_nettype wire

// ==== lp_dac_switch_ref_regs_tb.sv ====
`default_nettype none
module lp_dac_switch_ref_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        resetN;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire logic [31:0] hrdata;
	wire logic        hreadyout;
	wire logic        hresp;
	wire logic [4:0]  sw;
	wire logic [5:0]  sixBitCode;
	wire logic [11:0] twelveBitCode;
	wire logic        refPd;
	wire logic        bgPd;
	wire logic        cmEn;
	logic [31:0] refE, datE, cmE;
	logic [5:0]  swE;
	logic [6:0]  cfgE;
	int          errCount = 0;
	int          testsRun = 0;

	lpds_regs dut (.clk(clk), .reset_n(resetN), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.biasToPotentiostatSwitch(sw[4]), .biasToFilterPinSwitch(sw[3]), .zeroToLowpowerTiaSwitch(sw[2]),
		.zeroToFilterPinSwitch(sw[1]), .zeroToHighspeedTiaSwitch(sw[0]), .sixBitCode(sixBitCode),
		.twelveBitCode(twelveBitCode), .refBufferPowerdown(refPd), .bandgapPowerdown(bgPd),
		.commonModeEnable(cmEn));
	lpds_analog_model analog (.sixBitCode(sixBitCode), .twelveBitCode(twelveBitCode));

	function automatic logic [4:0] expSw(input logic [5:0] s, input logic [6:0] c);
		if (s[lpds_pkg::OVERRIDE_BIT])
			return s[4:0];
		return c[lpds_pkg::DIAG_BIT] ? lpds_pkg::SW_DIAG : lpds_pkg::SW_NORMAL;
	endfunction : expSw

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp)
		begin
			errCount++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic busXfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		hsize  <= 3'h2;
		htrans <= lpds_pkg::HTRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : busXfer

	task automatic readCheck(input string name, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		busXfer(1'b0, a, 32'h0000_0000, rd);
		check(name, exp, rd);
	endtask : readCheck

	task automatic regWrite(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] rd;
		busXfer(1'b1, a, d, rd);
		case (a)
			lpds_pkg::REF_CTRL_OFS: refE = d & 32'h0000_0003;
			lpds_pkg::DATA_OFS: datE = cfgE[0] ? d & 32'h0003_FFFF : 32'h0000_0000;
			lpds_pkg::SWITCH_OFS: swE = d[5:0];
			lpds_pkg::CONFIG_OFS: cfgE = d[6:0];
			lpds_pkg::CM_SEL_OFS: cmE = d & 32'h0000_000F;
			default: ;
		endcase
		if (!cfgE[0])
			datE = 32'h0000_0000;
	endtask : regWrite

	task automatic verifyAll();
		repeat (3) @(posedge clk);
		check("switches", {27'h0, expSw(swE, cfgE)}, {27'h0, sw});
		check("codes", datE, {14'h0, sixBitCode, twelveBitCode});
		check("zeroLevel", 200000 + 34375 * datE[17:12], analog.zeroLevelUv);
		check("biasLevel", 200000 + 537 * datE[11:0], analog.biasLevelUv);
		check("powerdown", refE, {30'h0, refPd, bgPd});
		check("commonModeEnable", {31'h0, cmE[3]}, {31'h0, cmEn});
		check("hresp", 32'h0, {31'h0, hresp});
		readCheck("ref", lpds_pkg::REF_CTRL_OFS, refE);
		readCheck("data", lpds_pkg::DATA_OFS, datE);
		readCheck("switch", lpds_pkg::SWITCH_OFS, {26'h0, swE});
		readCheck("config", lpds_pkg::CONFIG_OFS, {25'h0, cfgE});
		readCheck("commonMode", lpds_pkg::CM_SEL_OFS, cmE);
		readCheck("unmapped", 32'h0000_2130, 32'h0000_0000);
	endtask : verifyAll

	task automatic tallyAndFinish();
		if (errCount == 0 && testsRun > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tallyAndFinish

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		#(4 * 20000);
		errCount++;
		tallyAndFinish();
	end

	initial
	begin
		resetN = 1'b0;
		hsel   = 1'b0;
		haddr  = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0000_0000;
		{refE, datE, cmE} = '0;
		swE  = lpds_pkg::SWITCH_RST;
		cfgE = lpds_pkg::CONFIG_RST;
		void'($urandom(22518));
		repeat (6) @(posedge clk);
		resetN <= 1'b1;
		repeat (3) @(posedge clk);
		verifyAll();
		regWrite(lpds_pkg::DATA_OFS, 32'hFFFF_FFFF);
		verifyAll();
		regWrite(lpds_pkg::CONFIG_OFS, 32'h0000_0021);
		verifyAll();
		// Back-to-back writes, all-ones into data, common-mode and reference reserved bits; switch gets override only
		regWrite(lpds_pkg::DATA_OFS, 32'hFFFF_FFFF);
		regWrite(lpds_pkg::SWITCH_OFS, 32'h0000_0020);
		regWrite(lpds_pkg::CM_SEL_OFS, 32'hFFFF_FFFF);
		regWrite(lpds_pkg::REF_CTRL_OFS, 32'hFFFF_FFFF);
		verifyAll();
		for (int i = 0; i < 10; i++)
		begin
			regWrite(lpds_pkg::CONFIG_OFS, $urandom | 32'h0000_0001);
			regWrite(lpds_pkg::SWITCH_OFS, $urandom);
			regWrite(lpds_pkg::DATA_OFS, $urandom);
			regWrite(lpds_pkg::REF_CTRL_OFS, $urandom);
			regWrite(lpds_pkg::CM_SEL_OFS, $urandom);
			verifyAll();
		end
		regWrite(lpds_pkg::CONFIG_OFS, 32'h0000_0000);
		verifyAll();
		tallyAndFinish();
	end
endmodule : lp_dac_switch_ref_regs_tb
`default_nettype wire
